//--- hdl/fdrp_top.sv
// data recovery pump / read window clock and write precompensation selector
// assumes the vco arrives as a pin well below half the 10 MHz reference clock
`timescale 1ns/1ps
// Operation
// - write gate high disables recovery and floats both pumps
// - recovery enabled only when write gate and read enable input both low
// - pumps act only while raw read is low
// - falling edge early in window drives raise high, lower floats
// - falling edge late in window drives lower low, raise floats
// - edge in window centre leaves both pumps floating
// - read window clock is vco divided by 16 single, 8 double density
// - active pump holds while raw read stays low
// - double density: early/late sampled at write pulse edge pick a phase tap
// - write pulse leading edge sets the strobe and holds it
// - nominal uses phase tap 2, late uses phase tap 3
// - leading edge of phase tap 4 clears the strobe
// - inner track low or single density bypasses precompensation
// - density, inner track and raw read default to one when open
module fdrp_top (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic vco,
  input wire logic raw_read_pulse,
  input wire logic write_gate,
  input wire logic read_enable_fault_mux,
  input wire logic density_select_n,
  input wire logic inner_track_flag,
  input wire logic write_pulse_in,
  input wire logic early,
  input wire logic late,
  input wire logic [3:0] phase_tap,
  output fdrp_pkg::fdrp_pump_t pump,
  output logic read_window_clk,
  output logic precomp_strobe,
  output logic write_pulse_out
);
  logic vco_s, rr_s, wg_s, refm_s, dens_s, itf_s, wp_s, early_s, late_s;
  logic [3:0] tap_s;
  logic vco_prev_q, rr_prev_q, wp_prev_q, ph4_prev_q;
  logic [3:0] cnt_q;
  fdrp_pkg::fdrp_zone_t zone_q, zone_now, zone_calc;
  logic [1:0] sel_q;
  logic [5:0] pos3;
  logic vco_rise, rr_fall, wp_rise, ph4_rise, rec_en, bypass;
  logic [3:0] win_last;
  logic [5:0] win_len;

  // pulled-up pins reset high so an open pin reads as one
  fdrp_sync #(.W(3), .RST({3{fdrp_pkg::PIN_PULLUP}})) u_sync_pu (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d({density_select_n, inner_track_flag, raw_read_pulse}),
    .q({dens_s, itf_s, rr_s})
  );

  // remaining pins; write gate resets high so recovery starts disabled
  fdrp_sync #(.W(10), .RST({1'b1, 9'h000})) u_sync_in (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d({write_gate, read_enable_fault_mux, vco, write_pulse_in, early, late,
        phase_tap}),
    .q({wg_s, refm_s, vco_s, wp_s, early_s, late_s, tap_s})
  );

  // edge detection on the synchronised pins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      vco_prev_q <= fdrp_pkg::PIN_LOW;
      rr_prev_q <= fdrp_pkg::PIN_PULLUP;
      wp_prev_q <= fdrp_pkg::PIN_LOW;
      ph4_prev_q <= fdrp_pkg::PIN_LOW;
    end else begin
      vco_prev_q <= vco_s;
      rr_prev_q <= rr_s;
      wp_prev_q <= wp_s;
      ph4_prev_q <= tap_s[fdrp_pkg::TAP_END];
    end
  end

  assign vco_rise = vco_s & ~vco_prev_q;
  assign rr_fall = rr_prev_q & ~rr_s;
  assign wp_rise = wp_s & ~wp_prev_q;
  assign ph4_rise = tap_s[fdrp_pkg::TAP_END] & ~ph4_prev_q;
  assign rec_en = ~wg_s & ~refm_s;
  assign bypass = ~itf_s | dens_s;
  assign win_last = dens_s ? fdrp_pkg::WIN_LAST_SD : fdrp_pkg::WIN_LAST_DD;
  assign win_len = {1'b0, dens_s ? fdrp_pkg::WIN_LEN_SD : fdrp_pkg::WIN_LEN_DD};

  // window counter on vco edges; a change to double density mid-window just wraps early
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
    end else if (vco_rise) begin
      cnt_q <= (cnt_q >= win_last) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // read window clock from the count msb
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      read_window_clk <= 1'b0;
    end else begin
      read_window_clk <= dens_s ? cnt_q[fdrp_pkg::RCLK_BIT_SD]
                                : cnt_q[fdrp_pkg::RCLK_BIT_DD];
    end
  end

  // zone by thirds: 3*pos against len and 2*len avoids a divider
  always_comb begin
    pos3 = {2'h0, cnt_q} + {1'b0, cnt_q, 1'b0};
    if (pos3 < win_len) begin
      zone_calc = fdrp_pkg::FDRP_EARLY;
    end else if (pos3 >= {win_len[4:0], 1'b0}) begin
      zone_calc = fdrp_pkg::FDRP_LATE;
    end else begin
      zone_calc = fdrp_pkg::FDRP_CENTRE;
    end
  end

  assign zone_now = rr_fall ? zone_calc : zone_q;

  // zone is held for the whole low pulse
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      zone_q <= fdrp_pkg::FDRP_CENTRE;
    end else begin
      zone_q <= zone_now;
    end
  end

  // pump pins: raise only drives high, lower only drives low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pump <= '0;
    end else begin
      pump.raise_o <= 1'b1;
      pump.lower_o <= 1'b0;
      pump.raise_oe <= rec_en & ~rr_s & (zone_now == fdrp_pkg::FDRP_EARLY);
      pump.lower_oe <= rec_en & ~rr_s & (zone_now == fdrp_pkg::FDRP_LATE);
    end
  end

  // tap choice sampled at write pulse edge; both asserted falls back to nominal
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= fdrp_pkg::TAP_NOM;
    end else if (wp_rise & ~bypass) begin
      if (early_s & ~late_s) begin
        sel_q <= fdrp_pkg::TAP_EARLY;
      end else if (late_s & ~early_s) begin
        sel_q <= fdrp_pkg::TAP_LATE;
      end else begin
        sel_q <= fdrp_pkg::TAP_NOM;
      end
    end
  end

  // strobe: set beats a simultaneous phase 4 clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      precomp_strobe <= 1'b0;
    end else if (wp_rise & ~bypass) begin
      precomp_strobe <= 1'b1;
    end else if (ph4_rise) begin
      precomp_strobe <= 1'b0;
    end
  end

  // write data out: bypass copies the input, else the selected tap
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      write_pulse_out <= 1'b0;
    end else begin
      write_pulse_out <= bypass ? wp_s : tap_s[sel_q];
    end
  end

  // each check looks one edge after its cause, matching the registered pins
  wg_disable_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wg_s |=> !pump.raise_oe && !pump.lower_oe) else $error("pump driven during write");
  refm_disable_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    refm_s |=> !pump.raise_oe && !pump.lower_oe) else $error("pump driven, read off");
  rr_high_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rr_s |=> !pump.raise_oe && !pump.lower_oe) else $error("pump driven, raw high");
  early_raise_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rr_fall && rec_en && zone_calc == fdrp_pkg::FDRP_EARLY
    |=> pump.raise_oe && pump.raise_o && !pump.lower_oe) else $error("early edge no raise");
  late_lower_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rr_fall && rec_en && zone_calc == fdrp_pkg::FDRP_LATE
    |=> pump.lower_oe && !pump.lower_o && !pump.raise_oe) else $error("late edge no lower");
  centre_quiet_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rr_fall && zone_calc == fdrp_pkg::FDRP_CENTRE ##1 !rr_s && !rr_fall
    |-> !pump.raise_oe && !pump.lower_oe) else $error("centre edge pumped");
  window_wrap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    vco_rise && cnt_q == win_last && $stable(dens_s) |=> cnt_q == 4'h0)
    else $error("window count did not wrap");
  pump_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pump.raise_oe && rec_en && !rr_s && !rr_fall |=> pump.raise_oe)
    else $error("raise dropped while raw low");
  strobe_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wp_rise && !bypass |=> precomp_strobe [*1] ##1 (precomp_strobe || $past(ph4_rise)))
    else $error("strobe not set");
  tap_early_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wp_rise && !bypass && early_s && !late_s |=> sel_q == fdrp_pkg::TAP_EARLY)
    else $error("early tap not chosen");
  tap_late_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wp_rise && !bypass && late_s && !early_s |=> sel_q == fdrp_pkg::TAP_LATE)
    else $error("late tap not chosen");
  strobe_clr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ph4_rise && !(wp_rise && !bypass) |=> !precomp_strobe) else $error("strobe not cleared");
  bypass_copy_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    bypass |=> write_pulse_out == $past(wp_s)) else $error("bypass not copying");
  tap_nom_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wp_rise && !bypass && early_s == late_s |=> sel_q == fdrp_pkg::TAP_NOM)
    else $error("nominal tap not chosen");
  tap_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !bypass |=> write_pulse_out == $past(tap_s[sel_q]))
    else $error("write out not on selected tap");
  rclk_single_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dens_s |=> read_window_clk == $past(cnt_q[fdrp_pkg::RCLK_BIT_SD]))
    else $error("single density window clock wrong");
  rclk_double_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !dens_s |=> read_window_clk == $past(cnt_q[fdrp_pkg::RCLK_BIT_DD]))
    else $error("double density window clock wrong");
endmodule

//--- hdl/fdrp_pkg.sv
// shared constants and carrier types for the floppy data recovery / precomp block
// assumes one 10 MHz reference clock; all pins arrive asynchronously
package fdrp_pkg;
  localparam int unsigned REF_CLK_HZ = 10_000_000;
  localparam int unsigned SYNC_STAGES = 2;
  // window lengths in vco cycles
  localparam logic [4:0] WIN_LEN_SD = 5'h10;
  localparam logic [4:0] WIN_LEN_DD = 5'h08;
  localparam logic [3:0] WIN_LAST_SD = 4'hF;
  localparam logic [3:0] WIN_LAST_DD = 4'h7;
  // rclk is the msb of the window count
  localparam int unsigned RCLK_BIT_SD = 3;
  localparam int unsigned RCLK_BIT_DD = 2;
  // phase tap indices
  localparam logic [1:0] TAP_EARLY = 2'h0;
  localparam logic [1:0] TAP_NOM = 2'h1;
  localparam logic [1:0] TAP_LATE = 2'h2;
  localparam int unsigned TAP_END = 3;
  // reset levels of synchronised pins (pulled-up pins idle high)
  localparam logic PIN_PULLUP = 1'b1;
  localparam logic PIN_LOW = 1'b0;
  typedef enum logic [1:0] {FDRP_CENTRE, FDRP_EARLY, FDRP_LATE} fdrp_zone_t;
  // tri-state pump pins, enable high while driven
  typedef struct packed {
    logic raise_o;
    logic raise_oe;
    logic lower_o;
    logic lower_oe;
  } fdrp_pump_t;
endpackage

//--- hdl/fdrp_sync.sv
// two flip-flop synchroniser for a group of asynchronous pins
// assumes the reset value is a constant chosen by the instantiating module
`timescale 1ns/1ps
module fdrp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

//--- bench/fdrp_far_model.sv
// far-side model: vco source and four-phase write clock generator
// assumes a 10 MHz ref_clk and the block's strobe as a level
`timescale 1ns/1ps
module fdrp_far_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic precomp_strobe,
  output logic vco,
  output logic [3:0] phase_tap
);
  logic [1:0] div_q;
  logic [4:0] cnt_q;
  logic run_q;
  logic stb_q;
  // vco period 800 ns, slow enough for the pin synchroniser to see each level
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 2'h0;
      vco <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) vco <= ~vco;
    end
  end
  // one 8-cycle slot per tap after a strobe rise; tap 4 comes last to clear the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
      cnt_q <= 5'h00;
      stb_q <= 1'b0;
    end else begin
      stb_q <= precomp_strobe;
      if (precomp_strobe && !stb_q && !run_q) begin
        run_q <= 1'b1;
        cnt_q <= 5'h00;
      end else if (run_q) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == 5'h1F) run_q <= 1'b0;
      end
    end
  end
  assign phase_tap = run_q ? (4'h1 << cnt_q[4:3]) : 4'h0;
endmodule

//--- bench/testbench.sv
// self-checking bench: window clock, pump zones, gating, precomp and bypass
// assumes the far-side model supplies vco and the phase taps
`timescale 1ns/1ps
module testbench;
  logic ref_clk, arst_n, vco, raw, wg, refm, dens, itf, wpi, early, late;
  logic strobe, wpo, rclk;
  logic [3:0] tap;
  fdrp_pkg::fdrp_pump_t pump;
  logic [7:0] exp_q[$];
  logic [7:0] obs;
  int n_errors, compares, seed, rnd, n, m, k;
  event res_ev;
  fdrp_top fdrp_top_inst (.ref_clk(ref_clk), .arst_n(arst_n), .vco(vco),
    .raw_read_pulse(raw), .write_gate(wg), .read_enable_fault_mux(refm),
    .density_select_n(dens), .inner_track_flag(itf), .write_pulse_in(wpi),
    .early(early), .late(late), .phase_tap(tap), .pump(pump),
    .read_window_clk(rclk), .precomp_strobe(strobe), .write_pulse_out(wpo));
  fdrp_far_model fdrp_far_model_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .precomp_strobe(strobe), .vco(vco), .phase_tap(tap));
  // 100 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task tally_and_finish;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // note the expectation, then hand the observed value to the watcher
  task chk(input logic [7:0] e, input logic [7:0] g);
    exp_q.push_back(e);
    obs = g;
    ->res_ev;
    #1;
  endtask
  // watcher pairs each result with the oldest note
  initial forever begin
    @(res_ev);
    compares++;
    if (obs !== exp_q[0]) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, obs, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end
  // the whole run needs well under 3 ms
  initial begin
    #3000000;
    n_errors++;
    $display("unexpected at %0t: timeout", $time);
    tally_and_finish;
  end
  task waitn(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  // outputs are sampled on falling edges, away from the launch edge
  task wait_rclk(input logic v);
    n = 0;
    do begin @(negedge ref_clk); n++; end while (rclk !== v && n < 400);
  endtask
  task vco_rise;
    do @(negedge ref_clk); while (vco !== 1'b0);
    do @(negedge ref_clk); while (vco !== 1'b1);
  endtask
  // zone 0 lands at window start, 1 mid-window, 2 two vco counts later
  task pump_try(input int z, input logic [3:0] e);
    wait_rclk(z == 0);
    wait_rclk(z != 0);
    if (z == 2) begin
      vco_rise;
      vco_rise;
      waitn(2);
    end
    @(posedge ref_clk);
    raw <= 1'b0;
    waitn(6);
    chk({4'h0, e}, {4'h0, pump});
    @(posedge ref_clk);
    raw <= 1'b1;
    waitn(5);
    chk(8'h08, {4'h0, pump});
  endtask
  initial begin
    seed = 32'h09aa;
    n_errors = 0;
    compares = 0;
    arst_n = 1'b0;
    // write gate low so recovery is enabled once reset lets the pins through
    {raw, wg, refm, dens, itf, wpi, early, late} = 8'h98;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    // window period in ref cycles: vco is 8 cycles, so 128 single, 64 double
    for (k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      dens <= (k == 0);
      wait_rclk(0);
      wait_rclk(1);
      m = 0;
      do begin @(negedge ref_clk); m++; end while (rclk === 1'b1);
      do begin @(negedge ref_clk); m++; end while (rclk === 1'b0 && m < 400);
      chk(k ? 8'h40 : 8'h80, m[7:0]);
    end
    pump_try(0, 4'hC);
    pump_try(1, 4'h8);
    pump_try(2, 4'h9);
    // single density window: count 0 is early, count 8 sits in the centre third
    @(posedge ref_clk);
    dens <= 1'b1;
    waitn(4);
    pump_try(0, 4'hC);
    pump_try(1, 4'h8);
    @(posedge ref_clk);
    dens <= 1'b0;
    waitn(4);
    for (k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      wg <= k[0];
      refm <= k[1];
      waitn(4);
      pump_try(0, k == 0 ? 4'hC : 4'h8);
    end
    // each early/late pair selects one tap slot of the far-side generator
    for (k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      {late, early, wpi} <= {k[1], k[0], 1'b0};
      waitn(4);
      @(posedge ref_clk);
      wpi <= 1'b1;
      n = 0;
      do begin @(negedge ref_clk); n++; end while (strobe !== 1'b1 && n < 20);
      m = 0;
      do begin @(negedge ref_clk); m++; end while (wpo !== 1'b1 && m < 60);
      chk(8'h01, {7'h0, strobe});
      chk(k == 1 ? 8'h00 : k == 2 ? 8'h02 : 8'h01, {3'h0, m[7:3]});
      waitn(40);
      chk(8'h00, {7'h0, strobe});
    end
    // random write data passes straight through when precomp is off
    for (k = 0; k < 16; k++) begin
      rnd = $random(seed);
      @(posedge ref_clk);
      {itf, dens, wpi} <= {k[3], k[3], rnd[0]};
      waitn(5);
      chk({6'h0, wpi, 1'b0}, {6'h0, wpo, strobe});
    end
    tally_and_finish;
  end
endmodule
